/* hw/tws_slave.sv */
// Purpose: slave-only two-wire interface to config registers and EEPROM
// Assumes: scl/sda/straps are asynchronous pins, busy and boot from logic
// Notes:   storage reads are combinational on rd_addr_o
//
// Summary of operation
// - start and stop detected while clock high
// - lines idle high; stop frees, restart keeps
// - stop accepted anywhere except start's pulse
// - writes chain with or without restart
// - ack holds data low over ninth clock
// - transmit releases line, samples master ack
// - command nacked when busy, booting or illegal
// - address 1010, straps, ignored bit, r/w
// - single strap variant needs bit three zero
// - send byte loads pointer, nack if illegal
// - C0h block write, C1h block read
// - stop after special byte keeps pointer
// - C4h starts software reboot
// - write byte stores data at command address
// - register writes limited, invalid ones discarded
// - block write count one to sixteen
// - block pointer saturates; last register byte read-only
// - read byte via restart, one byte back
// - pointer advances after read unless boundary
// - refused command leaves pointer unchanged
// - block read sends count sixteen first
// - master nack or stop ends block read
// - register pointers 00h to 2Fh
// - config EEPROM 80h-B7h, user 40h-7Fh
// - nack everything until power-up load done
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_slave #(
	parameter bit SINGLE_STRAP = 1'b0,
	parameter int FIFO_DEPTH   = 16
) (
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	output logic                sda_o,
	output logic                sda_oe_n_o,
	input  wire logic           addr_strap_hi_i,
	input  wire logic           addr_strap_lo_i,
	input  wire logic           boot_done_i,
	input  wire logic           busy_i,
	output logic                reboot_o,
	output logic [7:0]          rd_addr_o,
	input  wire logic [7:0]     rd_data_i,
	output logic                wr_valid_o,
	input  wire logic           wr_ready_i,
	output tws_pkg::tws_wreq_type wr_o
);
	import tws_pkg::*;

	tws_slave_q_type q;
	tws_slave_q_type d;
	logic            fifo_rdy;
	logic            rise_e;
	logic            fall_e;
	logic            start_e;
	logic            stop_e;
	logic            byte_end;
	logic            preset;
	logic [3:0]      pins;

	assign pins = {addr_strap_lo_i, addr_strap_hi_i, sda_i, scl_i};

	// edges of the filtered lines
	assign rise_e  = q.filt[`TWS_PIN_SCL] && !q.prev[`TWS_PIN_SCL];
	assign fall_e  = !q.filt[`TWS_PIN_SCL] && q.prev[`TWS_PIN_SCL];
	assign start_e = q.filt[`TWS_PIN_SCL] && q.prev[`TWS_PIN_SCL] &&
		!q.filt[`TWS_PIN_SDA] && q.prev[`TWS_PIN_SDA];
	assign stop_e  = q.filt[`TWS_PIN_SCL] && q.prev[`TWS_PIN_SCL] &&
		q.filt[`TWS_PIN_SDA] && !q.prev[`TWS_PIN_SDA];
	assign byte_end = q.st == ST_RX && fall_e && q.bit_cnt == `TWS_BITS;
	// acked command byte of a send byte or read byte becomes the pointer
	assign preset   = q.st != ST_IDLE && q.ph == PH_SECOND &&
		!tws_special(q.cmd);

	assign sda_o      = 1'b0;
	assign sda_oe_n_o = !q.sda_low;
	assign reboot_o   = q.reboot;
	assign rd_addr_o  = q.ptr;

	tws_fifo #(
		.W     ($bits(tws_wreq_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (q.push),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (q.wreq),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  (wr_o)
	);

	always_comb begin
		logic [7:0] b;
		logic [7:0] tx;
		logic       ack;
		logic       hit;
		b   = q.sh;
		tx  = q.cnt_pend ? `TWS_BLK_RD_CNT : rd_data_i;
		ack = 1'b0;
		hit = b[7:4] == `TWS_DEV_CODE && b[2] == q.filt[`TWS_PIN_LO] &&
			(SINGLE_STRAP ? !b[3] : b[3] == q.filt[`TWS_PIN_HI]);
		d = q;
		d.reboot = 1'b0;
		d.push   = 1'b0;
		// three stage sampler, change taken when stages two and three agree
		d.s1   = pins;
		d.s2   = q.s1;
		d.s3   = q.s2;
		d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
		d.prev = q.filt;
		if (start_e) begin
			// repeated start keeps command and block read flag
			d.st       = ST_RX;
			d.ph       = PH_ADDR;
			d.bit_cnt  = '0;
			d.sda_low  = 1'b0;
			d.hi_start = 1'b1;
			if (preset) begin
				d.ptr = q.cmd;
			end
		end else if (stop_e && !q.hi_start) begin
			if (preset) begin
				d.ptr = q.cmd;
			end
			d.st      = ST_IDLE;
			d.sda_low = 1'b0;
			d.blk_rd  = 1'b0;
		end else begin
			if (fall_e) begin
				d.hi_start = 1'b0;
			end
			unique case (q.st)
				ST_IDLE, ST_IGNORE: begin
					d.sda_low = 1'b0;
				end
				ST_RX: begin
					if (rise_e) begin
						d.sh      = {q.sh[6:0], q.filt[`TWS_PIN_SDA]};
						d.bit_cnt = q.bit_cnt + 4'h1;
					end else if (byte_end) begin
						unique case (q.ph)
							PH_ADDR: begin
								if (hit && boot_done_i) begin
									ack = 1'b1;
									if (b[0]) begin
										d.ph       = PH_READ;
										d.cnt_pend = q.blk_rd;
									end else begin
										d.ph = PH_CMD;
									end
								end
							end
							PH_CMD: begin
								d.cmd = b;
								if (boot_done_i && !busy_i &&
									(tws_special(b) || tws_ptr_ok(b))) begin
									ack    = 1'b1;
									d.ph   = PH_SECOND;
									d.blk_rd = b == `TWS_CMD_BLK_RD;
									d.reboot = b == `TWS_CMD_REBOOT;
								end
							end
							PH_SECOND: begin
								if (q.cmd == `TWS_CMD_BLK_WR) begin
									ack = b != 8'h00 && b <= `TWS_BLK_MAX;
									d.cnt_left = b[4:0];
									d.ph       = PH_BLK;
								end else if (!tws_special(q.cmd)) begin
									ack       = fifo_rdy;
									d.ph      = PH_DONE;
									d.ptr     = q.cmd;
									d.wreq    = '{addr: q.cmd, data: b};
									d.push    = fifo_rdy &&
										q.cmd != `TWS_REG_END;
								end
							end
							PH_BLK: begin
								if (q.cnt_left != 5'h00 && fifo_rdy) begin
									ack        = 1'b1;
									d.wreq     = '{addr: q.ptr, data: b};
									d.push     = q.ptr != `TWS_REG_END;
									d.ptr      = tws_sat_inc(q.ptr);
									d.cnt_left = q.cnt_left - 5'h01;
								end
							end
							default: begin
								ack = 1'b0;
							end
						endcase
						d.sda_low = ack;
						d.st      = ack ? ST_RX_ACK : ST_IGNORE;
					end
				end
				ST_RX_ACK: begin
					if (fall_e) begin
						d.sda_low = 1'b0;
						d.bit_cnt = '0;
						if (q.ph == PH_READ) begin
							d.sh       = tx;
							d.sda_low  = !tx[7];
							d.bit_cnt  = 4'h1;
							d.st       = ST_TX;
						end else begin
							d.st = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (fall_e) begin
						if (q.bit_cnt == `TWS_BITS) begin
							d.sda_low = 1'b0;
							d.st      = ST_TX_ACK;
						end else begin
							d.sh      = {q.sh[6:0], 1'b0};
							d.sda_low = !q.sh[6];
							d.bit_cnt = q.bit_cnt + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (rise_e) begin
						d.mack = !q.filt[`TWS_PIN_SDA];
						d.cnt_pend = 1'b0;
						if (!q.cnt_pend) begin
							d.ptr = tws_sat_inc(q.ptr);
						end
					end else if (fall_e) begin
						if (q.mack) begin
							d.sh       = tx;
							d.sda_low  = !tx[7];
							d.bit_cnt  = 4'h1;
							d.st       = ST_TX;
						end else begin
							d.st = ST_IGNORE;
						end
					end
				end
				default: begin
					d.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_idle_released: assert property (
		q.st == ST_IDLE |-> sda_oe_n_o)
		else $error("data line driven while idle");

	a_start_to_rx: assert property (
		start_e |=> q.st == ST_RX && q.ph == PH_ADDR && q.bit_cnt == 4'h0)
		else $error("start not taken");

	a_stop_frees: assert property (
		stop_e && !q.hi_start |=> q.st == ST_IDLE && sda_oe_n_o)
		else $error("stop not taken");

	a_ack_holds: assert property (
		q.st == ST_RX_ACK && q.sda_low && !fall_e |=> !sda_oe_n_o)
		else $error("ack released early");

	a_tx_ack_free: assert property (
		q.st == ST_TX_ACK |-> sda_oe_n_o)
		else $error("line driven in master ack slot");

	a_busy_nack: assert property (
		byte_end && q.ph == PH_CMD && busy_i |=>
		sda_oe_n_o && q.st == ST_IGNORE)
		else $error("command acked while busy");

	a_addr_nibble: assert property (
		byte_end && q.ph == PH_ADDR && q.sh[7:4] != `TWS_DEV_CODE |=>
		sda_oe_n_o ##1 sda_oe_n_o)
		else $error("foreign address acked");

	a_single_strap: assert property (
		byte_end && q.ph == PH_ADDR && SINGLE_STRAP && q.sh[3] |=>
		sda_oe_n_o)
		else $error("bit three set acked in single strap mode");

	a_boot_nack: assert property (
		byte_end && q.ph == PH_ADDR && !boot_done_i |=> sda_oe_n_o)
		else $error("access acked before boot done");

	a_reboot_cmd: assert property (
		$rose(reboot_o) |-> q.cmd == `TWS_CMD_REBOOT ##1 !reboot_o)
		else $error("reboot pulse without command");

	a_count_range: assert property (
		byte_end && q.ph == PH_SECOND && q.cmd == `TWS_CMD_BLK_WR &&
		(q.sh == 8'h00 || q.sh > `TWS_BLK_MAX) |=> sda_oe_n_o)
		else $error("bad block count acked");

	a_ptr_sat: assert property (
		byte_end && q.ph == PH_BLK && q.ptr == `TWS_UE_END |=>
		q.ptr == `TWS_UE_END)
		else $error("pointer passed region end");

	a_ro_skip: assert property (
		q.push |-> q.wreq.addr != `TWS_REG_END)
		else $error("write to read-only location");

	a_read_inc: assert property (
		q.st == ST_TX_ACK && rise_e && !q.cnt_pend && !tws_at_end(q.ptr)
		|=> q.ptr == $past(q.ptr) + 8'h01)
		else $error("pointer not advanced after read");

	a_count_hold: assert property (
		q.st == ST_TX_ACK && rise_e && q.cnt_pend |=>
		q.ptr == $past(q.ptr))
		else $error("pointer moved after count byte");

	a_restart_load: assert property (
		start_e && preset |=> q.ptr == $past(q.cmd))
		else $error("pointer not preset at repeated start");

	a_nack_quiet: assert property (
		q.st == ST_IGNORE |-> sda_oe_n_o)
		else $error("line driven after nack");

	c_blk_write: cover property (q.ph == PH_BLK && q.push);
	c_blk_read:  cover property (q.st == ST_TX && q.blk_rd && !q.cnt_pend);
	c_reboot:    cover property (reboot_o);
	c_early_stop: cover property (stop_e && q.st == ST_TX);
endmodule : tws_slave

/* hw/tws_regs.svh */
// Purpose: bus codes, address map and bit counts of the two-wire slave
// Assumes: included by every design file that needs a code or boundary
// Notes:   definitions only
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_DEV_CODE   4'hA
`define TWS_CMD_BLK_WR 8'hC0
`define TWS_CMD_BLK_RD 8'hC1
`define TWS_CMD_REBOOT 8'hC4
`define TWS_REG_END    8'h2F
`define TWS_UE_LO      8'h40
`define TWS_UE_END     8'h7F
`define TWS_CE_END     8'hB7
`define TWS_BLK_MAX    8'h10
`define TWS_BLK_RD_CNT 8'h10
`define TWS_BITS       4'h8
`define TWS_PIN_SCL    0
`define TWS_PIN_SDA    1
`define TWS_PIN_HI     2
`define TWS_PIN_LO     3
`endif

/* hw/tws_pkg.sv */
// Purpose: types and helpers of the two-wire slave
// Assumes: tws_regs.svh holds the numbers
// Notes:   state enums carry no codes
`include "tws_regs.svh"
package tws_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
	} tws_state_type;

	typedef enum logic [2:0] {
		PH_ADDR, PH_CMD, PH_SECOND, PH_BLK, PH_DONE, PH_READ
	} tws_phase_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} tws_wreq_type;

	typedef struct packed {
		logic [3:0]    s1;
		logic [3:0]    s2;
		logic [3:0]    s3;
		logic [3:0]    filt;
		logic [3:0]    prev;
		tws_state_type st;
		tws_phase_type ph;
		logic [3:0]    bit_cnt;
		logic [7:0]    sh;
		logic [7:0]    cmd;
		logic [7:0]    ptr;
		logic [4:0]    cnt_left;
		logic          sda_low;
		logic          hi_start;
		logic          cnt_pend;
		logic          mack;
		logic          blk_rd;
		logic          reboot;
		logic          push;
		tws_wreq_type  wreq;
	} tws_slave_q_type;

	function automatic logic tws_special(input logic [7:0] b);
		return b == `TWS_CMD_BLK_WR || b == `TWS_CMD_BLK_RD ||
			b == `TWS_CMD_REBOOT;
	endfunction : tws_special

	function automatic logic tws_ptr_ok(input logic [7:0] p);
		return p <= `TWS_REG_END || (p >= `TWS_UE_LO && p <= `TWS_CE_END);
	endfunction : tws_ptr_ok

	function automatic logic tws_at_end(input logic [7:0] p);
		return p == `TWS_REG_END || p == `TWS_UE_END || p == `TWS_CE_END;
	endfunction : tws_at_end

	function automatic logic [7:0] tws_sat_inc(input logic [7:0] p);
		return tws_at_end(p) ? p : p + 8'h01;
	endfunction : tws_sat_inc
endpackage : tws_pkg

/* hw/tws_fifo.sv */
// Purpose: write request queue between bus side and storage side
// Assumes: DEPTH is a power of two
// Notes:   valid/ready on both sides, first word fall-through
`timescale 1ns/1ps
module tws_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wr;
		logic [AW:0]             rd;
	} tws_fifo_q_type;

	tws_fifo_q_type q;
	tws_fifo_q_type d;
	logic           full;
	logic           empty;

	assign empty       = q.wr == q.rd;
	assign full        = (q.wr[AW] != q.rd[AW]) &&
		(q.wr[AW-1:0] == q.rd[AW-1:0]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = q.mem[q.rd[AW-1:0]];

	always_comb begin
		d = q;
		if (in_valid_i && !full) begin
			d.mem[q.wr[AW-1:0]] = in_data_i;
			d.wr = q.wr + 1'b1;
		end
		if (out_ready_i && !empty) begin
			d.rd = q.rd + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : tws_fifo

/* bench/tws_master_model.sv */
// Purpose: bus master model for the two-wire slave
// Assumes: sda_i is the resolved wire, pulled up when released
// Notes:   clock stands high outside frames; bit is 8 clk, 6 low, 2 high
`timescale 1ns/1ps
module tws_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	initial begin
		scl_o      = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	task automatic qw();
		repeat (4) @(negedge clk_i);
	endtask : qw

	task automatic start();
		sda_oe_n_o = 1'b1;
		repeat (6) @(negedge clk_i);
		scl_o = 1'b1;
		qw();
		sda_oe_n_o = 1'b0;
		qw();
		scl_o = 1'b0;
		qw();
	endtask : start

	task automatic stop();
		sda_oe_n_o = 1'b0;
		qw();
		scl_o = 1'b1;
		qw();
		sda_oe_n_o = 1'b1;
		qw();
	endtask : stop

	task automatic bit_io(input logic b, output logic r);
		sda_oe_n_o = b;
		repeat (5) @(negedge clk_i);
		scl_o = 1'b1;
		@(negedge clk_i);
		r = sda_i;
		@(negedge clk_i);
		scl_o = 1'b0;
		@(negedge clk_i);
	endtask : bit_io

	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = (r === 1'b0);
	endtask : put

	task automatic get(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask : get
endmodule : tws_master_model

/* bench/tws_slave_tb.sv */
// Purpose: self-checking bench of the two-wire slave
// Assumes: storage answers rd_addr xor 5Ah; straps start hi=1, lo=0
// Notes:   write requests are checked in order from a queue
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("wrong value at %0t: %h not %h", $time, g, e); \
	end end
module tws_slave_tb;
	import tws_pkg::*;
	logic         clk_i, rst_n_i, scl, m_oe_n, s_o, s_oe_n, sda_w;
	logic         boot_done, busy, reboot, wr_valid, wr_ready, stall;
	logic         strap_hi, strap_lo;
	logic [7:0]   rd_addr;
	logic [31:0]  seed = 32'h1576_b9b1;
	tws_wreq_type wr, exp_w, exp_q[$];
	int           miscompares, cmp_count, reboots;

	assign sda_w = m_oe_n & (s_oe_n | s_o);

	tws_slave u_tws_slave (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(s_o), .sda_oe_n_o(s_oe_n), .addr_strap_hi_i(strap_hi),
		.addr_strap_lo_i(strap_lo), .boot_done_i(boot_done), .busy_i(busy),
		.reboot_o(reboot), .rd_addr_o(rd_addr),
		.rd_data_i(rd_addr ^ 8'h5A), .wr_valid_o(wr_valid),
		.wr_ready_i(wr_ready), .wr_o(wr)
	);

	tws_master_model u_tws_master_model (
		.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(m_oe_n)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(negedge clk_i) begin
		seed = lfsr(seed);
		wr_ready = ~stall & seed[0];
	end

	always @(posedge clk_i) begin
		if (reboot === 1'b1)
			reboots++;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("wrong value at %0t: unexpected write", $time);
			end else begin
				exp_w = exp_q.pop_front();
				`CHK(wr, exp_w)
			end
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic st();
		u_tws_master_model.start();
	endtask : st

	task automatic sp();
		u_tws_master_model.stop();
	endtask : sp

	task automatic put(input logic [7:0] b, input logic e);
		logic ack;
		u_tws_master_model.put(b, ack);
		`CHK(ack, e)
	endtask : put

	task automatic get(input logic nack, input logic [7:0] e);
		logic [7:0] d;
		u_tws_master_model.get(nack, d);
		`CHK(d, e)
	endtask : get

	task automatic sb(input logic [7:0] p, input logic e);
		st();
		put(8'hA8, 1'b1);
		put(p, e);
		sp();
	endtask : sb

	task automatic wbyte(input logic [7:0] c, input logic keep);
		logic [7:0] d;
		st();
		put(8'hA8, 1'b1);
		put(c, 1'b1);
		d = seed[15:8];
		if (keep)
			exp_q.push_back(tws_wreq_type'({c, d}));
		put(d, 1'b1);
	endtask : wbyte

	task automatic drain();
		for (int i = 0; i < 4000 && exp_q.size() != 0; i++)
			@(negedge clk_i);
		`CHK(exp_q.size(), 0)
	endtask : drain

	initial begin
		#2_000_000;
		miscompares++;
		conclude();
	end

	initial begin
		logic [7:0] bad[3] = '{8'hB8, 8'hA0, 8'hAC};
		logic [7:0] okp[6] = '{8'h00, 8'h2E, 8'h40, 8'h7F, 8'h80, 8'hB7};
		logic [7:0] nop[4] = '{8'h30, 8'h3F, 8'hB8, 8'hFF};
		logic [7:0] blk[3] = '{8'h2D, 8'h7E, 8'hB6};
		logic [7:0] p, d;
		logic       r;
		int         r0;
		rst_n_i = 1'b0;
		boot_done = 1'b0;
		busy = 1'b0;
		stall = 1'b0;
		strap_hi = 1'b1;
		strap_lo = 1'b0;
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (10) @(negedge clk_i);
		st();
		put(8'hA8, 1'b0);
		sp();
		boot_done = 1'b1;
		foreach (bad[i]) begin
			st();
			put(bad[i], 1'b0);
			sp();
		end
		{strap_hi, strap_lo} = 2'b01;
		st();
		put(8'hA8, 1'b0);
		sp();
		st();
		put(8'hA4, 1'b1);
		sp();
		{strap_hi, strap_lo} = 2'b10;
		st();
		repeat (4) u_tws_master_model.bit_io(1'b1, r);
		sp();
		st();
		put(8'hAA, 1'b1);
		sp();
		foreach (okp[i]) sb(okp[i], 1'b1);
		foreach (nop[i]) sb(nop[i], 1'b0);
		wbyte(8'h05, 1'b1);
		sp();
		wbyte(8'h2F, 1'b0);
		wbyte(8'h06, 1'b1);
		wbyte(8'h07, 1'b1);
		sp();
		sb(8'h20, 1'b1);
		busy = 1'b1;
		sb(8'h10, 1'b0);
		busy = 1'b0;
		st();
		put(8'hA9, 1'b1);
		get(1'b1, 8'h20 ^ 8'h5A);
		sp();
		st();
		put(8'hA8, 1'b1);
		put(8'h10, 1'b1);
		st();
		put(8'hA9, 1'b1);
		get(1'b1, 8'h10 ^ 8'h5A);
		sp();
		sb(8'hC0, 1'b1);
		st();
		put(8'hA9, 1'b1);
		get(1'b1, 8'h11 ^ 8'h5A);
		sp();
		foreach (blk[i]) begin
			sb(blk[i], 1'b1);
			st();
			put(8'hA8, 1'b1);
			put(8'hC0, 1'b1);
			put(8'h04, 1'b1);
			p = blk[i];
			repeat (4) begin
				d = seed[23:16];
				if (p != 8'h2F)
					exp_q.push_back(tws_wreq_type'({p, d}));
				put(d, 1'b1);
				if (p != 8'h2F && p != 8'h7F && p != 8'hB7)
					p++;
			end
			sp();
		end
		foreach (okp[i]) if (i < 2) begin
			st();
			put(8'hA8, 1'b1);
			put(8'hC0, 1'b1);
			put(i == 0 ? 8'h00 : 8'h11, 1'b0);
			sp();
		end
		sb(8'h7D, 1'b1);
		st();
		put(8'hA8, 1'b1);
		put(8'hC1, 1'b1);
		st();
		put(8'hA9, 1'b1);
		get(1'b0, 8'h10);
		get(1'b0, 8'h7D ^ 8'h5A);
		get(1'b0, 8'h7E ^ 8'h5A);
		get(1'b0, 8'h7F ^ 8'h5A);
		get(1'b1, 8'h7F ^ 8'h5A);
		sp();
		r0 = reboots;
		sb(8'hC4, 1'b1);
		`CHK(reboots, r0 + 1)
		drain();
		stall = 1'b1;
		sb(8'h40, 1'b1);
		st();
		put(8'hA8, 1'b1);
		put(8'hC0, 1'b1);
		put(8'h10, 1'b1);
		for (int i = 0; i < 16; i++) begin
			d = seed[15:8];
			exp_q.push_back(tws_wreq_type'({8'h40 + 8'(i), d}));
			put(d, 1'b1);
		end
		sp();
		st();
		put(8'hA8, 1'b1);
		put(8'hC0, 1'b1);
		put(8'h01, 1'b1);
		put(8'h33, 1'b0);
		sp();
		stall = 1'b0;
		drain();
		conclude();
	end
endmodule : tws_slave_tb
